/* File: include/pwmt_pkg.sv */
// shared constants and types for the three-channel pwm/capture timer
`default_nettype none
package pwmt_pkg;
	localparam int NUM_CH   = 3;
	localparam int NUM_CC   = 2;
	localparam int CNT_W    = 16;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int SRC_W    = 3;
	localparam int DIV_W    = 4;
	localparam int NUM_SRC  = 8;
	localparam int NUM_TICK = 4;
	localparam int INT_PER_CH = 3;

	// per-channel window: channel index in address bits [7:5]
	localparam int            CH_SHIFT      = 5;
	localparam logic [4:0]    OFF_CLK       = 5'h00;
	localparam logic [4:0]    OFF_CTL       = 5'h04;
	localparam logic [4:0]    OFF_MAX       = 5'h08;
	localparam logic [4:0]    OFF_COUNT     = 5'h0c;
	localparam logic [4:0]    OFF_CC0_CTL   = 5'h10;
	localparam logic [4:0]    OFF_CC0_VAL   = 5'h14;
	localparam logic [4:0]    OFF_CC1_CTL   = 5'h18;
	localparam logic [4:0]    OFF_CC1_VAL   = 5'h1c;
	localparam logic [7:0]    OFF_INT_STAT  = 8'h60;
	localparam logic [7:0]    OFF_INT_MASK  = 8'h64;
	localparam logic [7:0]    OFF_RUN_STAT  = 8'h68;

	// clock register fields
	localparam int CLK_SRC_LSB   = 0;
	localparam int CLK_DIV_LSB   = 4;
	localparam int CLK_RUN_IN_DEBUG_BIT = 8;
	// control register fields
	localparam int CTL_EN_BIT      = 0;
	localparam int CTL_RUN_BIT     = 1;
	localparam int CTL_PRESET_BIT  = 2;
	localparam int CTL_MODE_LSB    = 3;
	localparam int CTL_ONESHOT_BIT = 5;
	// comparator/capture control fields
	localparam int CC_CAPMODE_BIT = 0;
	localparam int CC_SWTRIG_BIT  = 1;
	localparam int CC_EDGE_LSB    = 2;
	localparam int CC_INV_BIT     = 4;
	// interrupt bits inside a channel's group of three
	localparam int INT_WRAP = 0;
	localparam int INT_CC0  = 1;

	// sources 4..7: pin 0, pin 0 inverted, pin 1, pin 1 inverted
	localparam logic [SRC_W-1:0] SRC_EXT_FIRST = 3'h4;
	localparam logic [CNT_W-1:0] MAX_RST       = 16'hffff;

	typedef enum logic [1:0] {PWMT_UP, PWMT_DOWN, PWMT_UPDOWN} pwmt_mode_t;
endpackage
`default_nettype wire

/* File: src/pwmt_clk_div.sv */
// count clock prescaler: divides a source tick by two to the power of the select
`timescale 1ns/1ns
`default_nettype none
module pwmt_clk_div #(
	parameter int DIV_W = pwmt_pkg::DIV_W
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic             enable,
	input  wire logic             sourceTick,
	input  wire logic [DIV_W-1:0] divideSelect,
	output logic                  countTick
);
	import pwmt_pkg::*;
	localparam int PRE_W = (2 ** DIV_W) - 1;

	typedef struct packed {
		logic [PRE_W-1:0] prescale;
	} pwmt_div_state_t;

	pwmt_div_state_t st;
	pwmt_div_state_t next_st;
	logic [PRE_W-1:0] mask;

	// prescaler keeps running across a select change; the first period after it may be short
	assign mask      = (PRE_W'(1) << divideSelect) - PRE_W'(1);
	assign countTick = enable & sourceTick & ((st.prescale & mask) == mask);

	always_comb begin
		next_st = st;
		if (enable && sourceTick) begin
			next_st.prescale = st.prescale + PRE_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	a_div_spacing: assert property (@(posedge core_clk) disable iff (!reset_n)
		enable && divideSelect != '0 && countTick |=> !countTick)
		else $error("divided tick repeated on consecutive cycles");
endmodule // pwmt_clk_div
`default_nettype wire

/* File: src/pwmt_cc_unit.sv */
// one comparator/capture circuit with its shared output/trigger pin
`timescale 1ns/1ns
`default_nettype none
module pwmt_cc_unit #(
	parameter int CW = pwmt_pkg::CNT_W
) (
	input  wire logic          core_clk,
	input  wire logic          reset_n,
	input  wire logic          active,
	input  wire logic          step,
	input  wire logic          wrap,
	input  wire logic [CW-1:0] count,
	input  wire logic [CW-1:0] compareValue,
	input  wire logic          captureMode,
	input  wire logic [1:0]    captureEdge,
	input  wire logic          swTrigger,
	input  wire logic          outInvert,
	input  wire logic          captureTriggerPin,
	output logic [CW-1:0]      captured,
	output logic               ccEvent,
	output logic               waveformOutputPin,
	output logic               waveformOutputPinOe
);
	import pwmt_pkg::*;

	typedef struct packed {
		logic          pinPrev;
		logic          wave;
		logic          ccEvent;
		logic [CW-1:0] captured;
	} pwmt_cc_state_t;

	pwmt_cc_state_t st;
	pwmt_cc_state_t next_st;
	logic pinRise;
	logic pinFall;
	logic trigger;
	logic match;

	assign pinRise = captureTriggerPin & ~st.pinPrev;
	assign pinFall = ~captureTriggerPin & st.pinPrev;
	assign trigger = active & captureMode &
		(swTrigger | (captureEdge[0] & pinRise) | (captureEdge[1] & pinFall));
	assign match   = step & ~captureMode & (count == compareValue);

	always_comb begin
		next_st         = st;
		next_st.pinPrev = captureTriggerPin;
		next_st.ccEvent = match | trigger;
		if (captureMode) begin
			next_st.wave = 1'b0;
		end else if (match) begin
			next_st.wave = 1'b1;
		end else if (wrap) begin
			next_st.wave = 1'b0;
		end
		if (trigger) begin
			next_st.captured = count;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign captured            = st.captured;
	assign ccEvent             = st.ccEvent;
	// pin drives low by default; in capture mode it is released to act as input
	assign waveformOutputPin   = ~captureMode & (st.wave ^ outInvert);
	assign waveformOutputPinOe = ~captureMode;

	a_capture_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
		trigger |=> captured == $past(count) && ccEvent)
		else $error("capture did not latch the counter");
	a_pin_direction: assert property (@(posedge core_clk) disable iff (!reset_n)
		captureMode |-> !waveformOutputPinOe && !waveformOutputPin)
		else $error("pin driven while in capture function");
	a_wave_match: assert property (@(posedge core_clk) disable iff (!reset_n)
		match && !captureMode ##1 !captureMode |-> waveformOutputPin == !outInvert)
		else $error("waveform not set on compare match");
	c_capture_pin: cover property (@(posedge core_clk) disable iff (!reset_n)
		trigger && !swTrigger);
endmodule // pwmt_cc_unit
`default_nettype wire

/* File: src/pwmt_timer.sv */
// three-channel 16-bit pwm timer with comparator/capture circuits and register port
//
// Functional notes
// - sixteen-bit up/down counter per channel
// - per-channel source select and division ratio
// - up, down, up/down; one-shot or repeat
// - event counting from external clock pins
// - two comparator/capture circuits per channel
// - compare match raises interrupt, shapes waveform
// - capture latches counter on pin/software trigger
// - three identical channels, indices zero to two
// - pin outputs waveform, or takes capture trigger
// - sleep-stop set: channel halts, state kept
// - sleep-stop clear: channel keeps running asleep
// - debug with run bit clear: channel halts
// - debug with run bit set: keeps counting
// - rising edges counted; inverted source gives falling
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pwmt_timer #(
	parameter int CHANNELS = pwmt_pkg::NUM_CH,
	parameter int CIRCUITS = pwmt_pkg::NUM_CC,
	parameter int CW       = pwmt_pkg::CNT_W
) (
	input  wire logic                          core_clk,
	input  wire logic                          reset_n,
	input  wire logic [pwmt_pkg::ADDR_W-1:0]   regAddr,
	input  wire logic [pwmt_pkg::DATA_W-1:0]   regWriteData,
	input  wire logic                          regWrite,
	input  wire logic                          regRead,
	output logic      [pwmt_pkg::DATA_W-1:0]   regReadData,
	output logic                               irq,
	input  wire logic                          sleepMode,
	input  wire logic                          debugMode,
	input  wire logic [pwmt_pkg::NUM_SRC-1:0]  sleepClockStop,
	input  wire logic [pwmt_pkg::NUM_TICK-1:0] clockSourceTick,
	input  wire logic [CHANNELS*2-1:0]         externalEventClockPin,
	input  wire logic [CHANNELS*CIRCUITS-1:0]  captureTriggerPin,
	output logic      [CHANNELS*CIRCUITS-1:0]  waveformOutputPin,
	output logic      [CHANNELS*CIRCUITS-1:0]  waveformOutputPinOe
);
	import pwmt_pkg::*;
	localparam int NCC   = CHANNELS * CIRCUITS;
	localparam int INT_W = CHANNELS * INT_PER_CH;

	typedef struct packed {
		logic [CHANNELS-1:0][SRC_W-1:0] clockSourceSelect;
		logic [CHANNELS-1:0][DIV_W-1:0] clockDivideSelect;
		logic [CHANNELS-1:0]            runInDebug;
		logic [CHANNELS-1:0]            chanEnable;
		logic [CHANNELS-1:0]            run;
		logic [CHANNELS-1:0]            oneShot;
		logic [CHANNELS-1:0]            countUp;
		pwmt_mode_t [CHANNELS-1:0]      countMode;
		logic [CHANNELS-1:0][CW-1:0]    maxValue;
		logic [CHANNELS-1:0][CW-1:0]    count;
		logic [CHANNELS*2-1:0]          extPrev;
		logic [NCC-1:0]                 captureMode;
		logic [NCC-1:0]                 outInvert;
		logic [NCC-1:0]                 swTrigger;
		logic [NCC-1:0][1:0]            captureEdge;
		logic [NCC-1:0][CW-1:0]         compareValue;
		logic [INT_W-1:0]               intStatus;
		logic [INT_W-1:0]               intMask;
		logic [DATA_W-1:0]              readData;
	} pwmt_state_t;

	pwmt_state_t st;
	pwmt_state_t next_st;

	logic [CHANNELS-1:0]   halt;
	logic [CHANNELS-1:0]   active;
	logic [CHANNELS-1:0]   sourceTick;
	logic [CHANNELS-1:0]   countTick;
	logic [CHANNELS-1:0]   step;
	logic [CHANNELS-1:0]   wrapNow;
	logic [NCC-1:0]        ccEvent;
	logic [NCC-1:0][CW-1:0] captured;
	logic [CHANNELS*2-1:0] extRise;
	logic [CHANNELS*2-1:0] extFall;

	assign extRise = externalEventClockPin & ~st.extPrev;
	assign extFall = ~externalEventClockPin & st.extPrev;

	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		logic [SRC_W-1:0] src;
		logic             extIdx;
		assign src    = st.clockSourceSelect[c];
		assign extIdx = src[1];
		// the sleep-stop bit is looked up by this channel's own clock source
		assign halt[c] = (sleepMode & sleepClockStop[src]) |
			(debugMode & ~st.runInDebug[c]);
		// gating the enable rather than the clock keeps every update whole
		assign active[c] = st.chanEnable[c] & ~halt[c];
		// external pin edge, inverted input selected by the low source bit
		assign sourceTick[c] = (src >= SRC_EXT_FIRST) ?
			(src[0] ? extFall[c*2+int'(extIdx)] : extRise[c*2+int'(extIdx)]) :
			clockSourceTick[src[1:0]];

		pwmt_clk_div #(
			.DIV_W (DIV_W)
		) u_div (
			.core_clk     (core_clk),
			.reset_n      (reset_n),
			.enable       (active[c]),
			.sourceTick   (sourceTick[c]),
			.divideSelect (st.clockDivideSelect[c]),
			.countTick    (countTick[c])
		);

		assign step[c] = active[c] & st.run[c] & countTick[c];
		assign wrapNow[c] = step[c] & (
			(st.countMode[c] == PWMT_DOWN) ? (st.count[c] == '0) :
			(st.countMode[c] == PWMT_UPDOWN) ? (!st.countUp[c] && st.count[c] == '0) :
			(st.count[c] >= st.maxValue[c]));

		for (genvar k = 0; k < CIRCUITS; k++) begin : g_cc
			localparam int I = c * CIRCUITS + k;
			pwmt_cc_unit #(
				.CW (CW)
			) u_cc (
				.core_clk            (core_clk),
				.reset_n             (reset_n),
				.active              (active[c]),
				.step                (step[c]),
				.wrap                (wrapNow[c]),
				.count               (st.count[c]),
				.compareValue        (st.compareValue[I]),
				.captureMode         (st.captureMode[I]),
				.captureEdge         (st.captureEdge[I]),
				.swTrigger           (st.swTrigger[I]),
				.outInvert           (st.outInvert[I]),
				.captureTriggerPin   (captureTriggerPin[I]),
				.captured            (captured[I]),
				.ccEvent             (ccEvent[I]),
				.waveformOutputPin   (waveformOutputPin[I]),
				.waveformOutputPinOe (waveformOutputPinOe[I])
			);
		end
	end

	always_comb begin
		logic            chHit;
		logic [4:0]      off;
		int              ci;
		chHit = 1'b0;
		off   = regAddr[4:0];
		ci    = 0;
		next_st          = st;
		next_st.extPrev  = externalEventClockPin;
		next_st.swTrigger = '0;
		next_st.readData = '0;

		// software writes; interrupt clears come first so a same-cycle event wins
		if (regWrite) begin
			if (regAddr == OFF_INT_STAT) begin
				next_st.intStatus = st.intStatus & ~regWriteData[INT_W-1:0];
			end
			if (regAddr == OFF_INT_MASK) begin
				next_st.intMask = regWriteData[INT_W-1:0];
			end
		end

		for (int c = 0; c < CHANNELS; c++) begin
			chHit = (int'(regAddr[ADDR_W-1:CH_SHIFT]) == c);
			ci    = c * CIRCUITS + int'(regAddr[3]);
			// counter stepping
			if (step[c]) begin
				case (st.countMode[c])
					PWMT_DOWN: begin
						if (st.count[c] == '0) begin
							next_st.count[c] = st.maxValue[c];
						end else begin
							next_st.count[c] = st.count[c] - CW'(1);
						end
					end
					PWMT_UPDOWN: begin
						if (st.countUp[c]) begin
							if (st.count[c] >= st.maxValue[c]) begin
								next_st.countUp[c] = 1'b0;
								if (st.count[c] != '0) begin
									next_st.count[c] = st.count[c] - CW'(1);
								end
							end else begin
								next_st.count[c] = st.count[c] + CW'(1);
							end
						end else if (st.count[c] == '0) begin
							if (!st.oneShot[c]) begin
								next_st.countUp[c] = 1'b1;
								if (st.maxValue[c] != '0) begin
									next_st.count[c] = CW'(1);
								end
							end
						end else begin
							next_st.count[c] = st.count[c] - CW'(1);
						end
					end
					default: begin
						if (st.count[c] >= st.maxValue[c]) begin
							next_st.count[c] = '0;
						end else begin
							next_st.count[c] = st.count[c] + CW'(1);
						end
					end
				endcase
				if (wrapNow[c] && st.oneShot[c]) begin
					next_st.run[c] = 1'b0;
				end
			end
			// channel register writes; a preset overrides a step in the same cycle
			if (regWrite && chHit) begin
				case (off)
					OFF_CLK: begin
						next_st.clockSourceSelect[c] = regWriteData[CLK_SRC_LSB +: SRC_W];
						next_st.clockDivideSelect[c] = regWriteData[CLK_DIV_LSB +: DIV_W];
						next_st.runInDebug[c]        = regWriteData[CLK_RUN_IN_DEBUG_BIT];
					end
					OFF_CTL: begin
						next_st.chanEnable[c] = regWriteData[CTL_EN_BIT];
						next_st.run[c]        = regWriteData[CTL_RUN_BIT];
						next_st.oneShot[c]    = regWriteData[CTL_ONESHOT_BIT];
						next_st.countMode[c]  = pwmt_mode_t'(regWriteData[CTL_MODE_LSB +: 2]);
						if (regWriteData[CTL_PRESET_BIT]) begin
							next_st.count[c]   = (st.countMode[c] == PWMT_DOWN) ?
								st.maxValue[c] : '0;
							next_st.countUp[c] = (st.countMode[c] != PWMT_DOWN);
						end
					end
					OFF_MAX: begin
						next_st.maxValue[c] = regWriteData[CW-1:0];
					end
					OFF_CC0_CTL, OFF_CC1_CTL: begin
						next_st.captureMode[ci] = regWriteData[CC_CAPMODE_BIT];
						next_st.swTrigger[ci]   = regWriteData[CC_SWTRIG_BIT];
						next_st.captureEdge[ci] = regWriteData[CC_EDGE_LSB +: 2];
						next_st.outInvert[ci]   = regWriteData[CC_INV_BIT];
					end
					OFF_CC0_VAL, OFF_CC1_VAL: begin
						next_st.compareValue[ci] = regWriteData[CW-1:0];
					end
					default: begin
					end
				endcase
			end
			// register reads
			if (regRead && chHit) begin
				case (off)
					OFF_CLK: begin
						next_st.readData[CLK_SRC_LSB +: SRC_W] = st.clockSourceSelect[c];
						next_st.readData[CLK_DIV_LSB +: DIV_W] = st.clockDivideSelect[c];
						next_st.readData[CLK_RUN_IN_DEBUG_BIT]        = st.runInDebug[c];
					end
					OFF_CTL: begin
						next_st.readData[CTL_EN_BIT]        = st.chanEnable[c];
						next_st.readData[CTL_RUN_BIT]       = st.run[c];
						next_st.readData[CTL_MODE_LSB +: 2] = st.countMode[c];
						next_st.readData[CTL_ONESHOT_BIT]   = st.oneShot[c];
					end
					OFF_MAX: begin
						next_st.readData[CW-1:0] = st.maxValue[c];
					end
					OFF_COUNT: begin
						next_st.readData[CW-1:0] = st.count[c];
					end
					OFF_CC0_CTL, OFF_CC1_CTL: begin
						next_st.readData[CC_CAPMODE_BIT]   = st.captureMode[ci];
						next_st.readData[CC_EDGE_LSB +: 2] = st.captureEdge[ci];
						next_st.readData[CC_INV_BIT]       = st.outInvert[ci];
					end
					OFF_CC0_VAL, OFF_CC1_VAL: begin
						next_st.readData[CW-1:0] = st.captureMode[ci] ?
							captured[ci] : st.compareValue[ci];
					end
					default: begin
					end
				endcase
			end
			// interrupt events set after any clear
			next_st.intStatus[c*INT_PER_CH+INT_WRAP] =
				next_st.intStatus[c*INT_PER_CH+INT_WRAP] | wrapNow[c];
			for (int k = 0; k < CIRCUITS; k++) begin
				next_st.intStatus[c*INT_PER_CH+INT_CC0+k] =
					next_st.intStatus[c*INT_PER_CH+INT_CC0+k] | ccEvent[c*CIRCUITS+k];
			end
		end

		if (regRead) begin
			case (regAddr)
				OFF_INT_STAT: next_st.readData[INT_W-1:0] = st.intStatus;
				OFF_INT_MASK: next_st.readData[INT_W-1:0] = st.intMask;
				OFF_RUN_STAT: begin
					for (int c = 0; c < CHANNELS; c++) begin
						next_st.readData[c*2]   = st.run[c];
						next_st.readData[c*2+1] = st.countUp[c];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st          <= '0;
			st.maxValue <= {CHANNELS{MAX_RST}};
		end else begin
			st <= next_st;
		end
	end

	assign regReadData = st.readData;
	assign irq         = |(st.intStatus & st.intMask);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_up_step: assert property (step[0] && st.countMode[0] == PWMT_UP &&
		st.count[0] < st.maxValue[0] && !regWrite |=> st.count[0] == $past(st.count[0]) + 1)
		else $error("up count did not advance by one");
	a_down_wrap: assert property (step[0] && st.countMode[0] == PWMT_DOWN &&
		st.count[0] == '0 && !regWrite |=> st.count[0] == $past(st.maxValue[0]))
		else $error("down count did not reload the maximum");
	a_oneshot_stop: assert property (wrapNow[0] && st.oneShot[0] && !regWrite
		|=> !st.run[0] ##1 $stable(st.count[0]) || $past(regWrite))
		else $error("one-shot did not stop at end of cycle");
	a_sleep_halt: assert property (sleepMode && sleepClockStop[st.clockSourceSelect[0]] &&
		!regWrite |=> $stable(st.count[0]) && $stable(st.run[0]))
		else $error("channel moved while sleep-stopped");
	a_sleep_run: assert property (sleepMode && !sleepClockStop[st.clockSourceSelect[0]] &&
		!debugMode && st.chanEnable[0] && st.run[0] && countTick[0] |-> step[0])
		else $error("channel stalled in sleep with stop bit clear");
	a_debug_halt: assert property (debugMode && !st.runInDebug[0] && !regWrite
		|=> $stable(st.count[0]))
		else $error("counter moved in debug with run bit clear");
	a_debug_run: assert property (debugMode && st.runInDebug[0] && !sleepMode &&
		st.chanEnable[0] && st.run[0] && countTick[0] |-> step[0])
		else $error("counter stalled in debug with run bit set");
	a_ext_edge: assert property (st.chanEnable[0] && !halt[0] &&
		st.clockSourceSelect[0] == SRC_EXT_FIRST |-> sourceTick[0] == extRise[0])
		else $error("event source does not follow pin rising edge");
	a_int_sticky: assert property (ccEvent[0] |=> st.intStatus[INT_CC0] ##1
		(st.intStatus[INT_CC0] || $past(regWrite)))
		else $error("circuit event lost from status");

	c_oneshot_end: cover property (wrapNow[0] && st.oneShot[0]);
	c_updown_turn: cover property (step[0] && st.countMode[0] == PWMT_UPDOWN ##1 !st.countUp[0]);
	c_irq_raised:  cover property (!irq ##1 irq);
	c_ext_count:   cover property (step[0] && st.clockSourceSelect[0] >= SRC_EXT_FIRST);
endmodule // pwmt_timer
`default_nettype wire

/* File: testbench/pwmt_pin_model.sv */
// pin-side model: external event clock pins and capture trigger pins
`timescale 1ns/1ns
`default_nettype none
module pwmt_pin_model (
	output logic [5:0] eventPin,
	output logic [5:0] trigPin,
	input  wire logic  core_clk
);
	initial begin
		eventPin = 6'h00;
		trigPin = 6'h00;
	end
	// each change is held long enough for the sampler and count step to land
	task automatic setEvent(input int p, input logic v);
		@(posedge core_clk);
		eventPin[p] <= v;
		repeat (5) @(posedge core_clk);
	endtask
	task automatic pulse(input int p, input int n);
		repeat (n) begin
			setEvent(p, 1'b1);
			setEvent(p, 1'b0);
		end
	endtask
	task automatic setTrig(input int p, input logic v);
		@(posedge core_clk);
		trigPin[p] <= v;
		repeat (5) @(posedge core_clk);
	endtask
endmodule // pwmt_pin_model
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the three-channel pwm/capture timer
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import pwmt_pkg::*;
	logic        core_clk;
	logic        reset_n;
	logic [7:0]  regAddr;
	logic [31:0] regWriteData;
	logic        regWrite;
	logic        regRead;
	logic [31:0] regReadData;
	logic        irq;
	logic        sleepMode;
	logic        debugMode;
	logic [7:0]  sleepClockStop;
	logic [5:0]  evPin;
	logic [5:0]  capPin;
	logic [5:0]  wavePin;
	logic [5:0]  waveOe;
	int          n_mismatch;
	int          checks_done;

	pwmt_timer i_dut (.core_clk, .reset_n, .regAddr, .regWriteData, .regWrite, .regRead,
		.regReadData, .irq, .sleepMode, .debugMode, .sleepClockStop, .clockSourceTick(4'hf),
		.externalEventClockPin(evPin), .captureTriggerPin(capPin),
		.waveformOutputPin(wavePin), .waveformOutputPinOe(waveOe));
	pwmt_pin_model i_pins (.eventPin(evPin), .trigPin(capPin), .core_clk);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 chk(regReadData & m, e);
	endtask
	task automatic mode(input logic s, input logic [7:0] st, input logic d);
		@(posedge core_clk);
		sleepMode <= s;
		sleepClockStop <= st;
		debugMode <= d;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#1000000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		n_mismatch = 0;
		checks_done = 0;
		reset_n = 1'b0;
		regAddr = 8'h00;
		regWriteData = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		sleepMode = 1'b0;
		debugMode = 1'b0;
		sleepClockStop = 8'h00;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		#1 chk({20'h0, waveOe, wavePin}, 32'hfc0);
		rd(8'h04, 32'h0);
		for (int c = 0; c < 3; c++) begin
			wr({c[2:0], OFF_MAX}, 32'h1230 + c);
			rd({c[2:0], OFF_MAX}, 32'h1230 + c);
			wr({c[2:0], OFF_MAX}, 32'hffff);
		end
		wr(8'h70, 32'h5);
		rd(8'h70, 32'h0);
		done("reset_map");
		// ch0: one-shot up to 2 on the core tick, cc0 matches 1 inverted, cc1 matches 0
		wr(8'h14, 32'h1);
		wr(8'h10, 32'h10);
		wr(8'h08, 32'h2);
		wr(8'h04, 32'h27);
		repeat (20) @(posedge core_clk);
		rd(8'h0c, 32'h0);
		rd(8'h68, 32'h0, 32'h1);
		rd(8'h60, 32'h7, 32'h7);
		chk({30'h0, wavePin[1:0]}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(8'h64, 32'h1);
		@(posedge core_clk);
		#1 chk({31'h0, irq}, 32'h1);
		wr(8'h60, 32'h7);
		@(posedge core_clk);
		#1 chk({31'h0, irq}, 32'h0);
		rd(8'h60, 32'h0, 32'h7);
		wr(8'h04, 32'h09);
		wr(8'h04, 32'h0d);
		rd(8'h0c, 32'h2);
		// one-shot up/down to 2 and back, then repeat down wrapping to the maximum
		wr(8'h04, 32'h11);
		wr(8'h04, 32'h37);
		repeat (10) @(posedge core_clk);
		rd(8'h0c, 32'h0);
		rd(8'h68, 32'h0, 32'h3);
		rd(8'h60, 32'h1, 32'h1);
		chk({30'h0, wavePin[1:0]}, 32'h3);
		wr(8'h04, 32'h0b);
		wr(8'h04, 32'h09);
		rd(8'h0c, 32'h1);
		done("oneshot_compare_irq");
		// ch1 counts pin 0 rising edges; edges during halts must be lost
		wr(8'h20, 32'h4);
		wr(8'h24, 32'h7);
		i_pins.pulse(2, 2);
		i_pins.pulse(2, 3);
		rd(8'h2c, 32'h5);
		mode(1'b1, 8'h10, 1'b0);
		i_pins.pulse(2, 3);
		rd(8'h2c, 32'h5);
		mode(1'b1, 8'h00, 1'b0);
		i_pins.pulse(2, 2);
		rd(8'h2c, 32'h7);
		mode(1'b0, 8'h10, 1'b1);
		i_pins.pulse(2, 2);
		rd(8'h2c, 32'h7);
		wr(8'h20, 32'h104);
		i_pins.pulse(2, 2);
		rd(8'h2c, 32'h9);
		mode(1'b0, 8'h00, 1'b0);
		// ch2 counts falling edges through the inverted source, then halves them
		wr(8'h40, 32'h5);
		wr(8'h44, 32'h7);
		i_pins.setEvent(4, 1'b1);
		rd(8'h4c, 32'h0);
		i_pins.setEvent(4, 1'b0);
		rd(8'h4c, 32'h1);
		wr(8'h40, 32'h15);
		i_pins.pulse(4, 4);
		rd(8'h4c, 32'h3);
		done("event_sleep_debug");
		// ch1 captures by software, then by a rising trigger pin edge
		wr(8'h60, 32'h1ff);
		wr(8'h30, 32'h3);
		rd(8'h34, 32'h9);
		wr(8'h38, 32'h5);
		i_pins.setTrig(3, 1'b1);
		rd(8'h3c, 32'h9);
		rd(8'h60, 32'h30);
		chk({26'h0, waveOe}, 32'h33);
		done("capture");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
